//--- crgc_ctrl.sv
// Purpose: control logic of the clock and reset generator
// Assumes: all inputs synchronous to clk_i; analog loop and oscillator outside
// Notes: control registers reinitialise on any system reset, reset flags do not
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module crgc_ctrl import crgc_pkg::*; #(
	parameter int unsigned WD_SHIFT = WD_BASE_SHIFT,
	parameter int unsigned PI_SHIFT = PI_BASE_SHIFT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic por_i,
	input wire logic lvr_i,
	input wire logic ila_i,
	input wire logic osc_loss_i,
	input wire logic quality_ok_i,
	input wire logic pll_lock_i,
	input wire logic wait_req_i,
	input wire logic stop_req_i,
	input wire logic wake_i,
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_o,
	output logic sys_reset_o,
	output logic osc_enable_o,
	output logic pll_enable_o,
	output logic sys_clk_pll_o,
	output logic self_clock_o,
	output logic [1:0] fm_sel_o,
	output logic irq_o
);
	logic [7:0] mul_q, mul_d, refd_q, refd_d, post_q, post_d, ien_q, ien_d;
	logic [7:0] csel_q, csel_d, lctl_q, lctl_d, pctl_q, pctl_d, wctl_q, wctl_d;
	logic periodic_timeout_flag_q, periodic_timeout_flag_d, power_on_reset_flag_q, power_on_reset_flag_d, low_voltage_reset_flag_q, low_voltage_reset_flag_d, lock_change_flag_q, lock_change_flag_d;
	logic lock_q, lock_d, illegal_access_reset_flag_q, illegal_access_reset_flag_d, self_clock_change_flag_q, self_clock_change_flag_d, scm_q, scm_d;
	crgc_mode_t mode_q, mode_d;
	logic [CW-1:0] wd_cnt_q, wd_cnt_d, pi_cnt_q, pi_cnt_d, wd_lim, pi_lim;
	logic armed_q, armed_d, wd_to, wd_bad, pi_hit, wd_run, pi_run, in_win;
	logic drive_q, drive_d, sys_rst_q, sys_rst_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic [7:0] rdata_d, flg_clr;
	logic irq_d, pll_en_d, osc_en_d, pll_sel_d, fast_wake, loss_det, int_src, cfg_rst;
	logic pll_en_q, osc_en_q, pll_sel_q, irq_q;

	// implemented bits per register, shared by the write and read paths
	function automatic logic [7:0] reg_mask(input logic [3:0] a);
		case (a)
			A_MUL, A_REFD, A_FLG, A_LCTL, A_PCTL: reg_mask = 8'hff;
			A_POST: reg_mask = M_POST;
			A_IEN: reg_mask = M_IEN;
			A_CSEL: reg_mask = M_CSEL;
			A_WCTL: reg_mask = M_WCTL;
			default: reg_mask = 8'h00;
		endcase
	endfunction

	// one less than a power of two cycles
	function automatic logic [CW-1:0] ones(input int unsigned n);
		ones = CW'((64'd1 << n) - 64'd1);
	endfunction

	assign cfg_rst = sys_rst_q;
	assign reset_pin_o = 1'b0; // open drain: only the enable ever changes
	assign flg_clr = (wr_i && addr_i == A_FLG) ? wdata_i : 8'h00;

	// software-visible control registers
	always_comb begin
		mul_d = mul_q;
		refd_d = refd_q;
		post_d = post_q;
		ien_d = ien_q;
		csel_d = csel_q;
		lctl_d = lctl_q;
		pctl_d = pctl_q;
		wctl_d = wctl_q;
		if (cfg_rst) begin
			mul_d = R_ZERO;
			refd_d = R_ZERO;
			post_d = R_ZERO;
			ien_d = R_ZERO;
			csel_d = R_CSEL;
			lctl_d = R_LCTL;
			pctl_d = R_ZERO;
			wctl_d = R_ZERO;
		end else if (wr_i) begin
			case (addr_i)
				A_MUL: if (!csel_q[B_CHOOSE]) mul_d = wdata_i;
				A_REFD: if (!csel_q[B_CHOOSE]) refd_d = wdata_i;
				A_POST: if (!csel_q[B_CHOOSE]) post_d = wdata_i & reg_mask(addr_i);
				A_IEN: ien_d = wdata_i & reg_mask(addr_i);
				A_CSEL: csel_d = wdata_i & reg_mask(addr_i);
				A_LCTL: lctl_d = wdata_i;
				A_PCTL: pctl_d = wdata_i;
				A_WCTL: begin
					// mask bit protects window and debug bits from this write
					if (wdata_i[B_WINDOW_WRITE_MASK]) begin
						wctl_d = {wctl_q[7:6], wdata_i[5:0] & M_WCTL[5:0]};
					end else begin
						wctl_d = wdata_i & reg_mask(addr_i);
					end
				end
				default: ;
			endcase
		end
	end

	// operating mode and self-clock state
	always_comb begin
		mode_d = mode_q;
		fast_wake = 1'b0;
		if (cfg_rst) begin
			mode_d = md_run;
		end else begin
			case (mode_q)
				md_run: begin
					if (stop_req_i) begin
						mode_d = csel_q[B_VARIANT] ? md_pseudo_stop : md_full_stop;
					end else if (wait_req_i) begin
						mode_d = md_wait;
					end
				end
				md_wait: if (wake_i) mode_d = md_run;
				md_full_stop, md_pseudo_stop: begin
					if (wake_i) begin
						mode_d = md_run;
						fast_wake = lctl_q[B_FASTWK];
					end
				end
				default: mode_d = md_run;
			endcase
		end
		// monitor is blind while the oscillator is deliberately off
		loss_det = lctl_q[B_CME] & osc_loss_i & (mode_q != md_full_stop);
		// entry beats a passing quality check in the same cycle
		if (cfg_rst) begin
			scm_d = 1'b0;
		end else begin
			scm_d = (scm_q & ~quality_ok_i) | (loss_det & lctl_q[B_SELF_CLOCK_ENABLE]) | fast_wake;
		end
		lock_d = pll_lock_i & ~scm_d;
	end

	// status flags, set wins over write-one-to-clear
	always_comb begin
		periodic_timeout_flag_d = (periodic_timeout_flag_q & ~flg_clr[7]) | pi_hit;
		power_on_reset_flag_d = (power_on_reset_flag_q & ~flg_clr[6]) | por_i;
		low_voltage_reset_flag_d = (low_voltage_reset_flag_q & ~flg_clr[5]) | lvr_i;
		lock_change_flag_d = (lock_change_flag_q & ~flg_clr[4]) | (lock_d != lock_q);
		illegal_access_reset_flag_d = ((illegal_access_reset_flag_q & ~flg_clr[2]) | ila_i) & ~por_i & ~lvr_i;
		self_clock_change_flag_d = (self_clock_change_flag_q & ~flg_clr[1]) | (scm_d != scm_q);
	end

	// watchdog and periodic counters
	always_comb begin
		wd_lim = ones(WD_SHIFT + 2 * int'(wctl_q[2:0]));
		pi_lim = (CW'(pctl_q[6:0]) << PI_SHIFT) | ones(PI_SHIFT);
		in_win = ~wctl_q[B_WINDOW] | (wd_cnt_q >= (wd_lim - (wd_lim >> 2)));
		case (mode_q)
			md_run: begin
				wd_run = 1'b1;
				pi_run = 1'b1;
			end
			md_wait: begin
				wd_run = ~csel_q[B_WDWAI];
				pi_run = ~csel_q[B_PERWAI];
			end
			md_pseudo_stop: begin
				wd_run = lctl_q[B_WDPS];
				pi_run = lctl_q[B_PERPS];
			end
			default: begin
				wd_run = 1'b0;
				pi_run = 1'b0;
			end
		endcase
		wd_run = wd_run & (wctl_q[2:0] != 3'h0);
		pi_run = pi_run & (pctl_q[6:0] != 7'h00);
		wd_cnt_d = wd_cnt_q;
		pi_cnt_d = pi_cnt_q;
		armed_d = armed_q;
		wd_to = 1'b0;
		wd_bad = 1'b0;
		pi_hit = 1'b0;
		if (cfg_rst) begin
			wd_cnt_d = '0;
			pi_cnt_d = '0;
			armed_d = 1'b0;
		end else begin
			if (wr_i && addr_i == A_SVC && wctl_q[2:0] != 3'h0) begin
				// early or wrong key is as fatal as a time-out
				if (!in_win) begin
					wd_bad = 1'b1;
				end else if (wdata_i == KEY_ARM) begin
					armed_d = 1'b1;
				end else if (wdata_i == KEY_CLR && armed_q) begin
					armed_d = 1'b0;
					wd_cnt_d = '0;
				end else begin
					wd_bad = 1'b1;
				end
			end else if (wd_run) begin
				if (wd_cnt_q >= wd_lim) begin
					wd_to = 1'b1;
				end else begin
					wd_cnt_d = wd_cnt_q + CW'(1);
				end
			end
			if (pi_run) begin
				if (pi_cnt_q >= pi_lim) begin
					pi_hit = 1'b1;
					pi_cnt_d = '0;
				end else begin
					pi_cnt_d = pi_cnt_q + CW'(1);
				end
			end
		end
	end

	// reset gathering and pin stretch
	always_comb begin
		int_src = por_i | lvr_i | ila_i | wd_to | wd_bad | (loss_det & ~lctl_q[B_SELF_CLOCK_ENABLE]);
		drive_d = drive_q;
		rcnt_d = rcnt_q;
		if (int_src) begin
			drive_d = 1'b1;
			rcnt_d = RST_STRETCH;
		end else if (drive_q) begin
			if (rcnt_q == 4'h0) begin
				drive_d = 1'b0;
			end else begin
				rcnt_d = rcnt_q - 4'h1;
			end
		end
		sys_rst_d = drive_d | ~reset_pin_i;
	end

	// clock steering, interrupt and read data
	always_comb begin
		osc_en_d = (mode_d != md_full_stop);
		pll_en_d = scm_d | (lctl_d[B_PWRON] & ~mode_d[1]
			& ~((mode_d == md_wait) & csel_d[B_LOOPWAI]));
		pll_sel_d = scm_d | csel_d[B_CHOOSE];
		irq_d = (periodic_timeout_flag_d & ien_d[7]) | (lock_change_flag_d & ien_d[4]) | (self_clock_change_flag_d & ien_d[1]);
		rdata_d = 8'h00;
		if (rd_i) begin
			case (addr_i)
				A_MUL: rdata_d = mul_q;
				A_REFD: rdata_d = refd_q;
				A_POST: rdata_d = post_q;
				A_FLG: rdata_d = {periodic_timeout_flag_q, power_on_reset_flag_q, low_voltage_reset_flag_q, lock_change_flag_q, lock_q, illegal_access_reset_flag_q, self_clock_change_flag_q, scm_q};
				A_IEN: rdata_d = ien_q;
				A_CSEL: rdata_d = csel_q;
				A_LCTL: rdata_d = lctl_q;
				A_PCTL: rdata_d = pctl_q;
				A_WCTL: rdata_d = wctl_q;
				default: rdata_d = 8'h00;
			endcase
			rdata_d = rdata_d & reg_mask(addr_i);
		end
	end

	// all state, frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mul_q <= R_ZERO;
			refd_q <= R_ZERO;
			post_q <= R_ZERO;
			ien_q <= R_ZERO;
			csel_q <= R_CSEL;
			lctl_q <= R_LCTL;
			pctl_q <= R_ZERO;
			wctl_q <= R_ZERO;
			{periodic_timeout_flag_q, power_on_reset_flag_q, low_voltage_reset_flag_q, lock_change_flag_q, lock_q, illegal_access_reset_flag_q, self_clock_change_flag_q, scm_q} <= 8'h00;
			mode_q <= md_run;
			wd_cnt_q <= '0;
			pi_cnt_q <= '0;
			armed_q <= 1'b0;
			drive_q <= 1'b0;
			rcnt_q <= 4'h0;
			sys_rst_q <= 1'b0;
			rdata_o <= 8'h00;
			irq_q <= 1'b0;
			pll_en_q <= 1'b1;
			osc_en_q <= 1'b1;
			pll_sel_q <= 1'b0;
		end else if (ce_i) begin
			mul_q <= mul_d;
			refd_q <= refd_d;
			post_q <= post_d;
			ien_q <= ien_d;
			csel_q <= csel_d;
			lctl_q <= lctl_d;
			pctl_q <= pctl_d;
			wctl_q <= wctl_d;
			{periodic_timeout_flag_q, power_on_reset_flag_q, low_voltage_reset_flag_q, lock_change_flag_q} <= {periodic_timeout_flag_d, power_on_reset_flag_d, low_voltage_reset_flag_d, lock_change_flag_d};
			{lock_q, illegal_access_reset_flag_q, self_clock_change_flag_q, scm_q} <= {lock_d, illegal_access_reset_flag_d, self_clock_change_flag_d, scm_d};
			mode_q <= mode_d;
			wd_cnt_q <= wd_cnt_d;
			pi_cnt_q <= pi_cnt_d;
			armed_q <= armed_d;
			drive_q <= drive_d;
			rcnt_q <= rcnt_d;
			sys_rst_q <= sys_rst_d;
			rdata_o <= rdata_d;
			irq_q <= irq_d;
			pll_en_q <= pll_en_d;
			osc_en_q <= osc_en_d;
			pll_sel_q <= pll_sel_d;
		end
	end

	assign reset_pin_oe_o = drive_q;
	assign sys_reset_o = sys_rst_q;
	assign osc_enable_o = osc_en_q;
	assign pll_enable_o = pll_en_q;
	assign sys_clk_pll_o = pll_sel_q;
	assign self_clock_o = scm_q; // also marks quality check in progress
	assign fm_sel_o = {lctl_q[B_FMHI], lctl_q[B_FMLO]};
	assign irq_o = irq_q;

	// checks
	chk_stop_variant_pick: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !sys_rst_q && mode_q == md_run && stop_req_i)
		|=> mode_q == ($past(csel_q[B_VARIANT]) ? md_pseudo_stop : md_full_stop))
		else $error("stop variant not honoured");
	chk_full_stop_osc: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_q == md_full_stop |-> !osc_enable_o && !pll_enable_o || self_clock_o)
		else $error("oscillator alive in full stop");
	chk_full_stop_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_q == md_full_stop && !sys_rst_q && !wr_i) |=> $stable(wd_cnt_q) && $stable(pi_cnt_q))
		else $error("counter moved in full stop");
	chk_pseudo_wd_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_q == md_pseudo_stop && !lctl_q[B_WDPS] && !sys_rst_q && !wr_i) |=> $stable(wd_cnt_q))
		else $error("watchdog moved in pseudo stop");
	chk_wait_loop_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_q == md_wait && csel_q[B_LOOPWAI] && !scm_q) |-> !pll_enable_o)
		else $error("loop running in wait");
	chk_self_clock_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !sys_rst_q && lctl_q[B_CME] && lctl_q[B_SELF_CLOCK_ENABLE] && osc_loss_i && mode_q != md_full_stop)
		|=> self_clock_o ##0 sys_clk_pll_o)
		else $error("self-clock not entered");
	chk_self_clock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !sys_rst_q && scm_q && !quality_ok_i) |=> scm_q)
		else $error("self-clock left before quality check");
	chk_reset_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && (por_i || wd_to || wd_bad)) |=> reset_pin_oe_o ##1 sys_reset_o || !ce_i)
		else $error("reset pin not pulled");
	chk_flag_keep_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && power_on_reset_flag_q && wr_i && addr_i == A_FLG && !wdata_i[6]) |=> power_on_reset_flag_q)
		else $error("flag cleared by zero write");
	chk_divider_locked: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == A_MUL && csel_q[B_CHOOSE] && !sys_rst_q) |=> $stable(mul_q))
		else $error("divider written while loop selected");
	chk_factory_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && rd_i && (addr_i == A_FBYP || addr_i == A_FTST)) |=> rdata_o == 8'h00)
		else $error("factory register read nonzero");
endmodule // crgc_ctrl

//--- crgc_pkg.sv
// Purpose: constants and types of the clock and reset generator control block
// Assumes: byte-wide register port, twelve registers at offsets 0x0 to 0xb
// Notes: counter lengths are module parameters so a simulation can shorten them
package crgc_pkg;
	localparam logic [3:0] A_MUL = 4'h0;
	localparam logic [3:0] A_REFD = 4'h1;
	localparam logic [3:0] A_POST = 4'h2;
	localparam logic [3:0] A_FLG = 4'h3;
	localparam logic [3:0] A_IEN = 4'h4;
	localparam logic [3:0] A_CSEL = 4'h5;
	localparam logic [3:0] A_LCTL = 4'h6;
	localparam logic [3:0] A_PCTL = 4'h7;
	localparam logic [3:0] A_WCTL = 4'h8;
	localparam logic [3:0] A_FBYP = 4'h9;
	localparam logic [3:0] A_FTST = 4'ha;
	localparam logic [3:0] A_SVC = 4'hb;
	// clock_select bits
	localparam int B_CHOOSE = 7;
	localparam int B_VARIANT = 6;
	localparam int B_LOOPWAI = 3;
	localparam int B_PERWAI = 1;
	localparam int B_WDWAI = 0;
	// loop_control bits
	localparam int B_CME = 7;
	localparam int B_PWRON = 6;
	localparam int B_FMHI = 5;
	localparam int B_FMLO = 4;
	localparam int B_FASTWK = 3;
	localparam int B_PERPS = 2;
	localparam int B_WDPS = 1;
	localparam int B_SELF_CLOCK_ENABLE = 0;
	// watchdog_control bits
	localparam int B_WINDOW = 7;
	localparam int B_WINDOW_WRITE_MASK = 5;
	// implemented-bit masks
	localparam logic [7:0] M_POST = 8'h1f;
	localparam logic [7:0] M_IEN = 8'h92;
	localparam logic [7:0] M_CSEL = 8'heb;
	localparam logic [7:0] M_WCTL = 8'hc7;
	// reset values
	localparam logic [7:0] R_CSEL = 8'h00;
	localparam logic [7:0] R_LCTL = 8'hc1;
	localparam logic [7:0] R_ZERO = 8'h00;
	// watchdog service keys
	localparam logic [7:0] KEY_ARM = 8'h55;
	localparam logic [7:0] KEY_CLR = 8'haa;
	// timing counts in cycles
	localparam logic [3:0] RST_STRETCH = 4'hf;
	localparam int unsigned WD_BASE_SHIFT = 8;
	localparam int unsigned PI_BASE_SHIFT = 10;
	localparam int CW = 24;
	typedef enum logic [1:0] {
		md_run = 2'b00,
		md_wait = 2'b01,
		md_full_stop = 2'b10,
		md_pseudo_stop = 2'b11
	} crgc_mode_t;
endpackage

//--- crgc_pin_model.sv
// Purpose: far-side model of the active-low open-drain reset pin
// Assumes: the board holds the pin high through a pull-up
// Notes: the device may only pull low; an outside pull-down wins over the pull-up
`timescale 1ns/1ps
module crgc_pin_model (
	input wire logic dev_oe_i,
	input wire logic dev_val_i,
	input wire logic ext_low_i,
	output logic pin_o
);
	// wired-and of both pull-downs; released pin floats up, never keeps its last value
	assign pin_o = ~((dev_oe_i & ~dev_val_i) | ext_low_i);
endmodule // crgc_pin_model

//--- crgc_ctrl_test.sv
// Purpose: self-checking bench of crgc_ctrl through its register port and mode inputs
// Assumes: counter shifts set to 2 so watchdog and periodic periods stay short
// Notes: outs packs {irq, fm_sel, self_clock, sys_clk_pll, pll_en, osc_en, sys_reset}
`timescale 1ns/1ps
module crgc_ctrl_test import crgc_pkg::*;;
	logic clk_i = 0, rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, ext_low = 0, reset_pin_i;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic por_i = 0, lvr_i = 0, ila_i = 0, osc_loss_i = 0, quality_ok_i = 0, pll_lock_i = 0;
	logic wait_req_i = 0, stop_req_i = 0, wake_i = 0;
	logic reset_pin_o, reset_pin_oe_o, sys_reset_o, osc_enable_o, pll_enable_o, sys_clk_pll_o, self_clock_o, irq_o;
	logic [1:0] fm_sel_o;
	wire logic [7:0] outs = {irq_o, fm_sel_o, self_clock_o, sys_clk_pll_o, pll_enable_o, osc_enable_o, sys_reset_o};
	logic [7:0] sv[3] = '{8'h00, 8'h40, 8'h40};
	logic [7:0] lv[3] = '{8'hc1, 8'hc1, 8'hc5};
	logic [7:0] pv[3] = '{8'h00, 8'h00, 8'h80};
	logic [7:0] fexp[8] = '{8'h40, 8'h20, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_total = 0;
	int tests_run = 0;
	int i, k;

	crgc_ctrl #(.WD_SHIFT(2), .PI_SHIFT(2)) u_crgc_ctrl (.clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .por_i, .lvr_i, .ila_i, .osc_loss_i, .quality_ok_i, .pll_lock_i, .wait_req_i, .stop_req_i,
		.wake_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .sys_reset_o, .osc_enable_o, .pll_enable_o,
		.sys_clk_pll_o, .self_clock_o, .fm_sel_o, .irq_o);
	crgc_pin_model u_crgc_pin_model (.dev_oe_i(reset_pin_oe_o), .dev_val_i(reset_pin_o), .ext_low_i(ext_low),
		.pin_o(reset_pin_i));

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// settle lets flops fed by the last request land before sampling
	task automatic settle();
		tick(1);
		@(negedge clk_i);
	endtask
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample at that negedge
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		cmp($sformatf("reg %h", a), exp, rdata_o);
		// the data must fall back to zero one cycle later
		@(negedge clk_i);
		cmp("rdata idle", 8'h00, rdata_o);
	endtask
	// one-cycle mode request: 0 wait, 1 stop, 2 wake
	task automatic go(input int m);
		@(posedge clk_i);
		{wake_i, stop_req_i, wait_req_i} <= 3'b001 << m;
		@(posedge clk_i);
		{wake_i, stop_req_i, wait_req_i} <= 3'b000;
		settle();
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard, far beyond the roughly one thousand cycles the sequence needs
	initial begin
		tick(20000);
		err_total++;
		end_sim();
	end

	initial begin
		tick(20);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp("outs", 8'h06, outs);
		cmp("pin oe", 8'h00, reset_pin_oe_o);
		// reset map, unmapped offset 0xc included
		for (k = 0; k < 13; k++) rd(k[3:0], (k == 6) ? R_LCTL : R_ZERO);
		// implemented-bit masks and the watchdog write mask
		wr(A_POST, 8'hff);
		rd(A_POST, 8'h1f);
		wr(A_IEN, 8'hff);
		rd(A_IEN, 8'h92);
		wr(A_WCTL, 8'hff);
		rd(A_WCTL, 8'h07);
		wr(A_WCTL, 8'h00);
		wr(A_CSEL, 8'hff);
		rd(A_CSEL, 8'heb);
		settle();
		cmp("outs", 8'h0e, outs);
		// divider writes refused while the loop clock is chosen
		wr(A_POST, 8'h05);
		wr(A_MUL, 8'h33);
		rd(A_POST, 8'h1f);
		rd(A_MUL, 8'h00);
		wr(A_CSEL, 8'h00);
		wr(A_MUL, 8'ha5);
		rd(A_MUL, 8'ha5);
		// a write while the clock enable is low must not land
		@(posedge clk_i) ce_i <= 1'b0;
		wr(A_MUL, 8'h11);
		@(posedge clk_i) ce_i <= 1'b1;
		rd(A_MUL, 8'ha5);
		settle();
		cmp("outs", 8'h06, outs);
		// modulation select follows loop_control bits 5:4
		wr(A_LCTL, 8'hf1);
		settle();
		cmp("outs", 8'h66, outs);
		wr(A_LCTL, 8'he1);
		settle();
		cmp("outs", 8'h46, outs);
		wr(A_LCTL, R_LCTL);
		// lock gained and lost, flag written with zero then one
		@(posedge clk_i) pll_lock_i <= 1'b1;
		tick(3);
		rd(A_FLG, 8'h18);
		cmp("outs", 8'h86, outs);
		wr(A_FLG, 8'h00);
		rd(A_FLG, 8'h18);
		wr(A_FLG, 8'h10);
		rd(A_FLG, 8'h08);
		settle();
		cmp("outs", 8'h06, outs);
		@(posedge clk_i) pll_lock_i <= 1'b0;
		tick(3);
		rd(A_FLG, 8'h10);
		wr(A_FLG, 8'h10);
		// wait mode with and without loop shut-off
		wr(A_CSEL, 8'h08);
		go(0);
		cmp("outs", 8'h02, outs);
		go(2);
		wr(A_CSEL, 8'h00);
		go(0);
		cmp("outs", 8'h06, outs);
		go(2);
		// full stop then pseudo stop
		go(1);
		cmp("outs", 8'h00, outs);
		go(2);
		cmp("outs", 8'h06, outs);
		wr(A_CSEL, 8'h40);
		go(1);
		cmp("outs", 8'h02, outs);
		go(2);
		// periodic counter runs, then frozen or running in each stop variant
		wr(A_PCTL, 8'h0f);
		tick(80);
		rd(A_FLG, 8'h80);
		cmp("outs", 8'h86, outs);
		for (k = 0; k < 3; k++) begin
			wr(A_CSEL, sv[k]);
			wr(A_LCTL, lv[k]);
			go(1);
			wr(A_FLG, 8'h80);
			tick(100);
			rd(A_FLG, pv[k]);
			go(2);
		end
		wr(A_PCTL, 8'h00);
		wr(A_FLG, 8'h80);
		wr(A_CSEL, 8'h00);
		// fast wake-up from full stop lands in self-clock mode
		wr(A_LCTL, 8'hc9);
		go(1);
		go(2);
		settle();
		cmp("outs", 8'h9e, outs);
		rd(A_FLG, 8'h03);
		@(posedge clk_i) quality_ok_i <= 1'b1;
		for (i = 0; i < 50 && self_clock_o !== 1'b0; i++) tick(1);
		cmp("self clock", 8'h00, self_clock_o);
		@(posedge clk_i) quality_ok_i <= 1'b0;
		wr(A_LCTL, R_LCTL);
		wr(A_FLG, 8'h02);
		// loss of clock with monitor and self-clock enabled; held until quality passes
		@(posedge clk_i) osc_loss_i <= 1'b1;
		tick(30);
		@(negedge clk_i);
		cmp("outs", 8'h9e, outs);
		@(posedge clk_i) osc_loss_i <= 1'b0;
		tick(10);
		@(negedge clk_i);
		cmp("self clock", 8'h01, self_clock_o);
		@(posedge clk_i) quality_ok_i <= 1'b1;
		for (i = 0; i < 50 && self_clock_o !== 1'b0; i++) tick(1);
		cmp("self clock", 8'h00, self_clock_o);
		@(posedge clk_i) quality_ok_i <= 1'b0;
		wr(A_FLG, 8'h02);
		// every reset source, pin driven low and flags surviving the reset
		for (k = 0; k < 8; k++) begin
			case (k)
				0: begin
					@(posedge clk_i) por_i <= 1'b1;
					@(posedge clk_i) por_i <= 1'b0;
				end
				1: begin
					@(posedge clk_i) lvr_i <= 1'b1;
					@(posedge clk_i) lvr_i <= 1'b0;
				end
				2: begin
					@(posedge clk_i) ila_i <= 1'b1;
					@(posedge clk_i) ila_i <= 1'b0;
				end
				3: begin
					wr(A_LCTL, 8'hc0);
					@(posedge clk_i) osc_loss_i <= 1'b1;
					@(posedge clk_i) osc_loss_i <= 1'b0;
				end
				4: wr(A_WCTL, 8'h01);
				5: begin
					wr(A_WCTL, 8'h01);
					repeat (5) begin
						wr(A_SVC, KEY_ARM);
						wr(A_SVC, KEY_CLR);
					end
					cmp("sys reset", 8'h00, sys_reset_o);
					wr(A_SVC, 8'h12);
				end
				6: begin
					wr(A_WCTL, 8'h81);
					wr(A_SVC, KEY_ARM);
				end
				default: begin
					@(posedge clk_i) ext_low <= 1'b1;
					tick(4);
				end
			endcase
			for (i = 0; i < 80 && sys_reset_o !== 1'b1; i++) tick(1);
			cmp("sys reset", 8'h01, sys_reset_o);
			if (k != 7) cmp("pin oe", 8'h01, reset_pin_oe_o);
			@(posedge clk_i) ext_low <= 1'b0;
			for (i = 0; i < 100 && sys_reset_o !== 1'b0; i++) tick(1);
			rd(A_FLG, fexp[k]);
			wr(A_FLG, 8'h64);
		end
		rd(A_WCTL, 8'h00);
		end_sim();
	end
endmodule // crgc_ctrl_test
